/* core/vmc_pkg.sv */
package vmc_pkg;

    // widths of the data paths
    localparam int VMC_SAMPLE_W = 14;
    localparam int VMC_THS_W    = 13;
    localparam int VMC_CNT_W    = 8;
    localparam int VMC_SQ_W     = 2 * VMC_SAMPLE_W + 1;
    localparam int VMC_SUM_W    = VMC_SQ_W + 2;

    // register indices; byte address is four times the index
    localparam logic [7:0] VMC_IDX_INT_SOURCE = 8'h0C;
    localparam logic [7:0] VMC_IDX_CFG        = 8'h5F;
    localparam logic [7:0] VMC_IDX_THS_HI     = 8'h60;
    localparam logic [7:0] VMC_IDX_THS_LO     = 8'h61;
    localparam logic [7:0] VMC_IDX_CNT        = 8'h62;
    localparam logic [7:0] VMC_IDX_INITX_HI   = 8'h63;
    localparam logic [7:0] VMC_IDX_INITX_LO   = 8'h64;
    localparam logic [7:0] VMC_IDX_INITY_HI   = 8'h65;
    localparam logic [7:0] VMC_IDX_INITY_LO   = 8'h66;
    localparam logic [7:0] VMC_IDX_INITZ_HI   = 8'h67;
    localparam logic [7:0] VMC_IDX_INITZ_LO   = 8'h68;

    // field positions
    localparam int VMC_CFG_ELE_BIT    = 6;
    localparam int VMC_CFG_INITM_BIT  = 5;
    localparam int VMC_CFG_UPDM_BIT   = 4;
    localparam int VMC_CFG_EN_BIT     = 3;
    localparam int VMC_THS_DBCNTM_BIT = 7;
    localparam int VMC_INTSRC_VM_BIT  = 1;

    // writable bits of the configuration and threshold-high registers
    localparam logic [7:0] VMC_CFG_MASK    = 8'h78;
    localparam logic [7:0] VMC_THS_HI_MASK = 8'h9F;

    // reset values
    localparam logic [7:0]              VMC_CFG_RST  = 8'h00;
    localparam logic [7:0]              VMC_THS_RST  = 8'h00;
    localparam logic [7:0]              VMC_CNT_RST  = 8'h00;
    localparam logic [VMC_SAMPLE_W-1:0] VMC_INIT_RST = 14'h0000;

    // bus answer
    localparam logic [1:0] VMC_HRESP_OKAY = 2'h0;

    // one three-axis sample or reference
    typedef struct packed {
        logic signed [VMC_SAMPLE_W-1:0] x;
        logic signed [VMC_SAMPLE_W-1:0] y;
        logic signed [VMC_SAMPLE_W-1:0] z;
    } vmc_vec_t;

    // captured bus address phase
    typedef struct packed {
        logic       valid;
        logic       write;
        logic       mapped;
        logic [7:0] idx;
    } vmc_aph_t;

endpackage

/* core/vmc_axis_sq.sv */
`timescale 1ns/10ps
module vmc_axis_sq
    import vmc_pkg::*;
#(
    parameter int W = VMC_SAMPLE_W
) (
    input  wire logic signed [W-1:0] cur_val,
    input  wire logic signed [W-1:0] ref_val,
    output logic             [2*W:0] sq_out
);
    // signed difference, one bit wider than the operands
    logic signed [W:0]       diff;
    // magnitude of the difference
    logic        [W:0]       mag;
    // full product before trimming
    logic        [2*W+1:0]   prod;

    // squared axis difference, no sign needed
    always_comb begin
        diff   = cur_val - ref_val;
        mag    = diff[W] ? (W+1)'(0) - diff : diff;
        prod   = mag * mag;
        sq_out = prod[2*W:0];
    end
endmodule

/* core/vmc_top.sv */
`timescale 1ns/10ps
module vmc_top
    import vmc_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic      [31:0] hrdata,
    output logic      [1:0]  hresp,
    input  wire logic        sample_strobe,
    input  wire vmc_vec_t    sample_in,
    output logic             vm_event
);
    // bus state
    vmc_aph_t              dph_reg,   dph_next;    // data phase in progress
    logic                  rdone_reg, rdone_next;  // read wait cycle spent
    logic [31:0]           rdat_reg,  rdat_next;   // read data register
    // software registers
    logic [7:0]            cfg_reg,   cfg_next;    // mode bits
    logic [7:0]            thsh_reg,  thsh_next;   // clear mode and threshold high
    logic [7:0]            thsl_reg,  thsl_next;   // threshold low
    logic [7:0]            cnt_lim_reg, cnt_lim_next; // debounce count
    vmc_vec_t              init_reg,  init_next;   // initial reference values
    // detector state
    vmc_vec_t              ref_reg,   ref_next;    // held reference, never read out
    vmc_vec_t              last_reg,  last_next;   // most recent sample
    logic [VMC_CNT_W-1:0]  cnt_reg,   cnt_next;    // debounce counter
    logic                  hit_reg,   hit_next;    // debounced condition
    logic                  latch_reg, latch_next;  // latched event
    logic                  en_d_reg,  en_d_next;   // enable one cycle ago
    logic                  flag_reg,  flag_next;   // event output
    // helper wires
    logic                  wr_en;                  // write data phase
    logic                  rd_go;                  // read data taken this cycle
    logic                  clr;                    // interrupt-source read
    logic                  en_rise;                // function just enabled
    logic                  eval;                   // sample to evaluate
    logic                  above;                  // magnitude above threshold
    logic                  trig;                   // event triggers now
    logic [VMC_THS_W-1:0]  ths_val;                // 13-bit threshold
    logic [2*VMC_THS_W-1:0] ths_sq;                // squared threshold
    logic [VMC_SQ_W-1:0]   sqx, sqy, sqz;          // squared axis distances
    logic [VMC_SUM_W-1:0]  sq_sum;                 // squared magnitude
    logic [7:0]            rd_byte;                // addressed register value

    // one squarer per axis
    vmc_axis_sq u_sqx (.cur_val(sample_in.x), .ref_val(ref_reg.x), .sq_out(sqx));
    vmc_axis_sq u_sqy (.cur_val(sample_in.y), .ref_val(ref_reg.y), .sq_out(sqy));
    vmc_axis_sq u_sqz (.cur_val(sample_in.z), .ref_val(ref_reg.z), .sq_out(sqz));

    // squared comparison avoids a root and decides the same
    assign ths_val = {thsh_reg[4:0], thsl_reg};
    assign ths_sq  = ths_val * ths_val;
    assign sq_sum  = {2'h0, sqx} + {2'h0, sqy} + {2'h0, sqz};
    assign above   = sq_sum > {5'h00, ths_sq};

    // bus strobes; reads take one wait cycle so data is registered
    assign wr_en     = dph_reg.valid && dph_reg.write;
    assign rd_go     = dph_reg.valid && !dph_reg.write && !rdone_reg;
    assign clr       = rd_go && dph_reg.mapped && (dph_reg.idx == VMC_IDX_INT_SOURCE);
    assign hreadyout = !rd_go;
    assign hrdata    = rdat_reg;
    assign hresp     = VMC_HRESP_OKAY;

    // detector qualifiers
    assign en_rise = cfg_reg[VMC_CFG_EN_BIT] && !en_d_reg;
    assign eval    = sample_strobe && cfg_reg[VMC_CFG_EN_BIT] && en_d_reg;
    assign trig    = eval && above && (cnt_reg >= cnt_lim_reg) && !hit_reg;
    assign vm_event = flag_reg;

    // read mux; the held reference has no address
    always_comb begin
        rd_byte = 8'h00;
        if (!dph_reg.mapped) begin
            rd_byte = 8'h00;
        end else if (dph_reg.idx == VMC_IDX_INT_SOURCE) begin
            rd_byte[VMC_INTSRC_VM_BIT] = flag_reg;
        end else if (dph_reg.idx == VMC_IDX_CFG) begin
            rd_byte = cfg_reg & VMC_CFG_MASK;
        end else if (dph_reg.idx == VMC_IDX_THS_HI) begin
            rd_byte = thsh_reg & VMC_THS_HI_MASK;
        end else if (dph_reg.idx == VMC_IDX_THS_LO) begin
            rd_byte = thsl_reg;
        end else if (dph_reg.idx == VMC_IDX_CNT) begin
            rd_byte = cnt_lim_reg;
        end else if (dph_reg.idx == VMC_IDX_INITX_HI) begin
            rd_byte = {2'h0, init_reg.x[13:8]};
        end else if (dph_reg.idx == VMC_IDX_INITX_LO) begin
            rd_byte = init_reg.x[7:0];
        end else if (dph_reg.idx == VMC_IDX_INITY_HI) begin
            rd_byte = {2'h0, init_reg.y[13:8]};
        end else if (dph_reg.idx == VMC_IDX_INITY_LO) begin
            rd_byte = init_reg.y[7:0];
        end else if (dph_reg.idx == VMC_IDX_INITZ_HI) begin
            rd_byte = {2'h0, init_reg.z[13:8]};
        end else if (dph_reg.idx == VMC_IDX_INITZ_LO) begin
            rd_byte = init_reg.z[7:0];
        end
    end

    // next values of bus state and software registers
    always_comb begin
        dph_next     = dph_reg;
        rdone_next   = rdone_reg;
        rdat_next    = rdat_reg;
        cfg_next     = cfg_reg;
        thsh_next    = thsh_reg;
        thsl_next    = thsl_reg;
        cnt_lim_next = cnt_lim_reg;
        init_next    = init_reg;
        // read data loads in the wait cycle
        if (rd_go) begin
            rdat_next  = {24'h000000, rd_byte};
            rdone_next = 1'b1;
        end
        // address phase taken whenever the bus is ready
        if (hready) begin
            dph_next.valid  = hsel && htrans[1];
            dph_next.write  = hwrite;
            dph_next.mapped = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
            dph_next.idx    = haddr[9:2];
            rdone_next      = 1'b0;
        end
        // register writes; unmapped writes are dropped
        if (wr_en && dph_reg.mapped) begin
            if (dph_reg.idx == VMC_IDX_CFG) begin
                cfg_next = hwdata[7:0] & VMC_CFG_MASK;
            end else if (dph_reg.idx == VMC_IDX_THS_HI) begin
                thsh_next = hwdata[7:0] & VMC_THS_HI_MASK;
            end else if (dph_reg.idx == VMC_IDX_THS_LO) begin
                thsl_next = hwdata[7:0];
            end else if (dph_reg.idx == VMC_IDX_CNT) begin
                cnt_lim_next = hwdata[7:0];
            end else if (dph_reg.idx == VMC_IDX_INITX_HI) begin
                init_next.x[13:8] = hwdata[5:0];
            end else if (dph_reg.idx == VMC_IDX_INITX_LO) begin
                init_next.x[7:0] = hwdata[7:0];
            end else if (dph_reg.idx == VMC_IDX_INITY_HI) begin
                init_next.y[13:8] = hwdata[5:0];
            end else if (dph_reg.idx == VMC_IDX_INITY_LO) begin
                init_next.y[7:0] = hwdata[7:0];
            end else if (dph_reg.idx == VMC_IDX_INITZ_HI) begin
                init_next.z[13:8] = hwdata[5:0];
            end else if (dph_reg.idx == VMC_IDX_INITZ_LO) begin
                init_next.z[7:0] = hwdata[7:0];
            end
        end
    end

    // register bus state and software registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_reg     <= '0;
            rdone_reg   <= 1'b0;
            rdat_reg    <= 32'h00000000;
            cfg_reg     <= VMC_CFG_RST;
            thsh_reg    <= VMC_THS_RST;
            thsl_reg    <= VMC_THS_RST;
            cnt_lim_reg <= VMC_CNT_RST;
            init_reg    <= {VMC_INIT_RST, VMC_INIT_RST, VMC_INIT_RST};
        end else begin
            dph_reg     <= dph_next;
            rdone_reg   <= rdone_next;
            rdat_reg    <= rdat_next;
            cfg_reg     <= cfg_next;
            thsh_reg    <= thsh_next;
            thsl_reg    <= thsl_next;
            cnt_lim_reg <= cnt_lim_next;
            init_reg    <= init_next;
        end
    end

    // next values of the detector
    always_comb begin
        ref_next   = ref_reg;
        last_next  = sample_strobe ? sample_in : last_reg;
        cnt_next   = cnt_reg;
        hit_next   = hit_reg;
        en_d_next  = cfg_reg[VMC_CFG_EN_BIT];
        // reference source
        if (en_rise) begin
            ref_next = cfg_reg[VMC_CFG_INITM_BIT] ? init_reg : last_reg;
        end else if (cfg_reg[VMC_CFG_EN_BIT] && cfg_reg[VMC_CFG_INITM_BIT]
                     && cfg_reg[VMC_CFG_UPDM_BIT]) begin
            ref_next = init_reg;
        end else if (trig && !cfg_reg[VMC_CFG_UPDM_BIT]) begin
            ref_next = sample_in;
        end
        // debounce counter
        if (!cfg_reg[VMC_CFG_EN_BIT]) begin
            cnt_next = '0;
            hit_next = 1'b0;
        end else if (eval && above) begin
            if (cnt_reg >= cnt_lim_reg) begin
                cnt_next = cnt_lim_reg;
                hit_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + 8'h01;
            end
        end else if (eval) begin
            if (thsh_reg[VMC_THS_DBCNTM_BIT] || cnt_reg == '0) begin
                cnt_next = '0;
            end else begin
                cnt_next = cnt_reg - 8'h01;
            end
            if (thsh_reg[VMC_THS_DBCNTM_BIT] || cnt_reg <= 8'h01) begin
                hit_next = 1'b0;
            end
        end
        // latched copy; a new trigger wins over the clearing read
        latch_next = (latch_reg && !clr) || (trig && cfg_reg[VMC_CFG_ELE_BIT]);
        flag_next  = cfg_reg[VMC_CFG_ELE_BIT] ? latch_next : hit_next;
    end

    // register the detector
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ref_reg   <= '0;
            last_reg  <= '0;
            cnt_reg   <= '0;
            hit_reg   <= 1'b0;
            latch_reg <= 1'b0;
            en_d_reg  <= 1'b0;
            flag_reg  <= 1'b0;
        end else begin
            ref_reg   <= ref_next;
            last_reg  <= last_next;
            cnt_reg   <= cnt_next;
            hit_reg   <= hit_next;
            latch_reg <= latch_next;
            en_d_reg  <= en_d_next;
            flag_reg  <= flag_next;
        end
    end

    // checks
    property p_trig_cause;
        @(posedge hclk) disable iff (!hresetn)
        trig |-> above && (cnt_reg >= cnt_lim_reg) ##1 hit_reg;
    endproperty
    a_trig_cause: assert property (p_trig_cause) else $error("trigger without cause");

    property p_load_cur;
        @(posedge hclk) disable iff (!hresetn)
        en_rise && !cfg_reg[VMC_CFG_INITM_BIT] |=> ref_reg == $past(last_reg);
    endproperty
    a_load_cur: assert property (p_load_cur) else $error("sample not captured");

    property p_load_init;
        @(posedge hclk) disable iff (!hresetn)
        en_rise && cfg_reg[VMC_CFG_INITM_BIT] |=> ref_reg == $past(init_reg);
    endproperty
    a_load_init: assert property (p_load_init) else $error("init not loaded");

    property p_refresh;
        @(posedge hclk) disable iff (!hresetn)
        trig && !cfg_reg[VMC_CFG_UPDM_BIT] && !en_rise |=> ref_reg == $past(sample_in);
    endproperty
    a_refresh: assert property (p_refresh) else $error("reference not refreshed");

    property p_hold_ref;
        @(posedge hclk) disable iff (!hresetn)
        en_d_reg && cfg_reg[VMC_CFG_EN_BIT] && cfg_reg[VMC_CFG_UPDM_BIT]
            && !cfg_reg[VMC_CFG_INITM_BIT] |=> $stable(ref_reg);
    endproperty
    a_hold_ref: assert property (p_hold_ref) else $error("reference moved");

    property p_live_init;
        @(posedge hclk) disable iff (!hresetn)
        wr_en && cfg_reg[VMC_CFG_EN_BIT] && en_d_reg && cfg_reg[VMC_CFG_INITM_BIT]
            && cfg_reg[VMC_CFG_UPDM_BIT] && cfg_next == cfg_reg ##1 1'b1 |=> ref_reg == $past(init_reg);
    endproperty
    a_live_init: assert property (p_live_init) else $error("live init not applied");

    property p_latched;
        @(posedge hclk) disable iff (!hresetn)
        cfg_reg[VMC_CFG_ELE_BIT] && latch_reg && !clr |=> vm_event;
    endproperty
    a_latched: assert property (p_latched) else $error("latched flag lost");

    property p_realtime;
        @(posedge hclk) disable iff (!hresetn)
        !cfg_reg[VMC_CFG_ELE_BIT] && eval && above && (cnt_reg >= cnt_lim_reg) |=> vm_event;
    endproperty
    a_realtime: assert property (p_realtime) else $error("flag not real time");

    property p_decrement;
        @(posedge hclk) disable iff (!hresetn)
        eval && !above && !thsh_reg[VMC_THS_DBCNTM_BIT] && cnt_reg != '0
            |=> cnt_reg == $past(cnt_reg) - 8'h01;
    endproperty
    a_decrement: assert property (p_decrement) else $error("counter not decremented");

    property p_disabled;
        @(posedge hclk) disable iff (!hresetn)
        !cfg_reg[VMC_CFG_EN_BIT] |=> cnt_reg == '0 && !hit_reg;
    endproperty
    a_disabled: assert property (p_disabled) else $error("active while disabled");

    property p_read_wait;
        @(posedge hclk) disable iff (!hresetn)
        hready && hsel && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout;
    endproperty
    a_read_wait: assert property (p_read_wait) else $error("read wait wrong");

    c_trig:  cover property (@(posedge hclk) disable iff (!hresetn) trig);
    c_clear: cover property (@(posedge hclk) disable iff (!hresetn) clr && latch_reg);
    c_init:  cover property (@(posedge hclk) disable iff (!hresetn)
                             en_rise && cfg_reg[VMC_CFG_INITM_BIT]);
endmodule

/* testbench/tb.sv */
`timescale 1ns/10ps
module tb
    import vmc_pkg::*;
();

    // bus and sample stimulus
    logic            hclk;
    logic            hresetn;
    logic            hsel;
    logic     [31:0] haddr;
    logic     [1:0]  htrans;
    logic            hwrite;
    logic     [2:0]  hsize;
    logic     [31:0] hwdata;
    logic            hreadyout;
    logic     [31:0] hrdata;
    logic     [1:0]  hresp;
    logic            sample_strobe;
    vmc_vec_t        sample_in;
    logic            vm_event;
    // outputs sampled mid-cycle, settled well before the next edge
    logic            rdy_n;
    logic     [31:0] rd_n;
    logic            ev_n;
    // bookkeeping
    int              n_errors;
    int              n_tests;
    int              cyc;

    // one slave, so its ready is the bus ready
    vmc_top u_vmc_top (
        .hclk          (hclk),
        .hresetn       (hresetn),
        .hsel          (hsel),
        .haddr         (haddr),
        .htrans        (htrans),
        .hwrite        (hwrite),
        .hsize         (hsize),
        .hwdata        (hwdata),
        .hready        (hreadyout),
        .hreadyout     (hreadyout),
        .hrdata        (hrdata),
        .hresp         (hresp),
        .sample_strobe (sample_strobe),
        .sample_in     (sample_in),
        .vm_event      (vm_event)
    );

    // free running bus clock, 100 ns period
    always #50 hclk = ~hclk;

    // capture outputs at the falling edge so no edge race decides a check
    always @(negedge hclk) begin
        rdy_n <= hreadyout;
        rd_n  <= hrdata;
        ev_n  <= vm_event;
    end

    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 2000) begin
            n_errors++;
            conclude();
        end
    end

    // verdict and end of run
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // compare seen against expected
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // single word write; entered right after a rising edge
    task automatic bus_wr(input logic [7:0] idx, input logic [7:0] d);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {22'h000000, idx, 2'b00};
        hwrite <= 1'b1;
        do @(posedge hclk); while (rdy_n !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {24'h000000, d};
        do @(posedge hclk); while (rdy_n !== 1'b1);
    endtask

    // single word read, then compare the returned word
    task automatic bus_rd(input string nm, input logic [7:0] idx, input logic [31:0] exp);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {22'h000000, idx, 2'b00};
        hwrite <= 1'b0;
        do @(posedge hclk); while (rdy_n !== 1'b1);
        htrans <= 2'h0;
        do @(posedge hclk); while (rdy_n !== 1'b1);
        chk(nm, rd_n, exp);
    endtask

    // x-only sample vector
    function automatic vmc_vec_t mk(input int x);
        mk   = '0;
        mk.x = x[13:0];
    endfunction

    // one strobe, then let the flag settle; strobes stay four clocks apart
    task automatic smp(input vmc_vec_t v);
        sample_in     <= v;
        sample_strobe <= 1'b1;
        @(posedge hclk);
        sample_strobe <= 1'b0;
        repeat (3) @(posedge hclk);
    endtask

    // main sequence
    initial begin
        hclk = 1'b0; hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'h0;
        hwrite = 1'b0; hsize = 3'h2; hwdata = '0; sample_strobe = 1'b0;
        sample_in = '0; n_errors = 0; n_tests = 0; cyc = 0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // registers: reset values, writable bits, unmapped place
        bus_rd("cfg_rst", VMC_IDX_CFG, 32'h00000000);
        bus_rd("ths_rst", VMC_IDX_THS_HI, 32'h00000000);
        bus_rd("cnt_rst", VMC_IDX_CNT, 32'h00000000);
        bus_wr(VMC_IDX_CFG, 8'hFF);
        bus_rd("cfg_bits", VMC_IDX_CFG, 32'h00000078);
        bus_wr(VMC_IDX_THS_HI, 8'hFF);
        bus_rd("ths_bits", VMC_IDX_THS_HI, 32'h0000009F);
        bus_wr(8'h70, 8'hA5);
        bus_rd("unmapped", 8'h70, 32'h00000000);
        chk("hresp", {30'h0, hresp}, {30'h0, VMC_HRESP_OKAY});
        bus_wr(VMC_IDX_CFG, 8'h00);
        // threshold 100, count 0, clear mode: an ignored enable would trigger here
        bus_wr(VMC_IDX_THS_HI, 8'h80);
        bus_wr(VMC_IDX_THS_LO, 8'h64);
        smp(mk(2000));
        chk("off_evt", {31'h0, ev_n}, 32'h0);
        $display("test registers done");
        // count 2, capture from samples; the first sample exposes a missed capture
        bus_wr(VMC_IDX_CNT, 8'h02);
        smp(mk(1000));
        bus_wr(VMC_IDX_CFG, 8'h08);
        // the first enabled cycle takes no sample
        @(posedge hclk);
        for (int i = 0; i < 5; i++) begin
            smp(mk(i == 0 ? 1050 : 1200));
            chk("evt_cap", {31'h0, ev_n}, {31'h0, i == 3});
        end
        $display("test capture done");
        // count 3, decrement mode, initial values, hold reference
        bus_wr(VMC_IDX_CFG, 8'h00);
        bus_wr(VMC_IDX_THS_HI, 8'h00);
        bus_wr(VMC_IDX_CNT, 8'h03);
        bus_wr(VMC_IDX_INITX_HI, 8'h3E);
        bus_wr(VMC_IDX_INITX_LO, 8'hD4);
        bus_rd("initx_hi", VMC_IDX_INITX_HI, 32'h0000003E);
        bus_wr(VMC_IDX_CFG, 8'h38);
        @(posedge hclk);
        for (int i = 0; i < 7; i++) begin
            smp(mk(i < 4 ? 0 : -300));
            chk("evt_dec", {31'h0, ev_n}, {31'h0, i >= 3 && i <= 5});
        end
        $display("test decrement done");
        // latched flag, cleared by the source read; live reference writes
        bus_wr(VMC_IDX_CFG, 8'h00);
        bus_wr(VMC_IDX_CNT, 8'h00);
        bus_wr(VMC_IDX_CFG, 8'h78);
        @(posedge hclk);
        smp(mk(0));
        chk("lat_set", {31'h0, ev_n}, 32'h1);
        smp(mk(-300));
        chk("lat_hold", {31'h0, ev_n}, 32'h1);
        bus_rd("int_src", VMC_IDX_INT_SOURCE, 32'h00000002);
        chk("lat_clr", {31'h0, ev_n}, 32'h0);
        bus_wr(VMC_IDX_INITX_HI, 8'h00);
        bus_wr(VMC_IDX_INITX_LO, 8'h00);
        smp(mk(-300));
        chk("live_ref", {31'h0, ev_n}, 32'h1);
        bus_rd("int_src2", VMC_IDX_INT_SOURCE, 32'h00000002);
        bus_rd("int_src3", VMC_IDX_INT_SOURCE, 32'h00000000);
        $display("test latch done");
        // update hold with a captured reference: no refresh on trigger
        bus_wr(VMC_IDX_CFG, 8'h00);
        smp(mk(0));
        bus_wr(VMC_IDX_CFG, 8'h18);
        @(posedge hclk);
        smp(mk(200));
        chk("hold_set", {31'h0, ev_n}, 32'h1);
        smp(mk(200));
        chk("hold_ref", {31'h0, ev_n}, 32'h1);
        $display("test hold done");
        conclude();
    end
endmodule
